// File: common/dpd_pkg.sv
package dpd_pkg;
  // register byte offsets on the slave port
  localparam logic [5:0] OFF_CTRL    = 6'h00;
  localparam logic [5:0] OFF_SRC     = 6'h04;
  localparam logic [5:0] OFF_CNT     = 6'h08;
  localparam logic [5:0] OFF_DST     = 6'h0C;
  localparam logic [5:0] OFF_LINK    = 6'h10;
  localparam logic [5:0] OFF_STAT    = 6'h14;
  localparam logic [5:0] OFF_TRIG    = 6'h18;
  localparam logic [5:0] OFF_LCTRL   = 6'h20;
  localparam logic [5:0] OFF_LSRC    = 6'h24;
  localparam logic [5:0] OFF_LCNT    = 6'h28;
  localparam logic [5:0] OFF_LDST    = 6'h2C;
  // channel_control_word fields
  localparam int BIT_SRC_MODE  = 0;
  localparam int BIT_DST_MODE  = 1;
  localparam int BIT_DIM       = 2;
  localparam int BIT_HOLD      = 3;
  localparam int FWC_LSB       = 8;
  localparam int FWC_W         = 3;
  localparam logic [2:0] FWC_LAST_LEGAL = 3'h5;
  // array_and_byte_counts fields
  localparam int BYTES_LSB     = 0;
  localparam int ARRAYS_LSB    = 16;
  localparam int CNT_W         = 16;
  // status word fields
  localparam int ST_BUSY       = 0;
  localparam int ST_EXHAUSTED  = 1;
  localparam int ST_REFUSED    = 2;
  localparam int ST_MISSED     = 3;
  localparam int ST_PENDING    = 4;
  localparam int TRIG_BIT      = 0;
  localparam logic [15:0] NULL_LINK  = 16'hFFFF;
  localparam logic [31:0] RST_WORD   = 32'h0000_0000;
  localparam logic [15:0] RST_LINK   = 16'hFFFF;
  localparam int SPAN_W        = 6;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ISSUE  = 2'b01,
    ST_UPDATE = 2'b10
  } dpd_state_type;
endpackage

// File: common/dpd_opt_if.sv
`timescale 1ns/1ps
interface dpd_opt_if;
  logic [2:0]  fifoWidthCode;
  logic        sourceAddressMode;
  logic        destinationAddressMode;
  logic [31:0] sourceStartAddress;
  logic [31:0] destinationStartAddress;
  logic [15:0] bytesPerArray;
  logic [5:0]  srcSpan;
  logic [5:0]  dstSpan;
  logic        codeBad;
  logic [31:0] nextSrc;
  logic [31:0] nextDst;

  modport owner (
    output fifoWidthCode, sourceAddressMode, destinationAddressMode,
    output sourceStartAddress, destinationStartAddress, bytesPerArray,
    input  srcSpan, dstSpan, codeBad, nextSrc, nextDst
  );
  modport decode (
    input  fifoWidthCode, sourceAddressMode, destinationAddressMode,
    output srcSpan, dstSpan, codeBad
  );
  modport step (
    input  sourceAddressMode, destinationAddressMode,
    input  sourceStartAddress, destinationStartAddress, bytesPerArray,
    output nextSrc, nextDst
  );
endinterface

// File: design/dpd_span_decode.sv
`timescale 1ns/1ps
module dpd_span_decode (
  dpd_opt_if.decode opt
);
  import dpd_pkg::*;

  // span in bytes: 1 << code, so code 0 is one byte and 5 is 32 bytes
  function automatic logic [SPAN_W-1:0] spanOf(input logic [2:0] code);
    spanOf = (code > FWC_LAST_LEGAL) ? '0 : SPAN_W'(1) << code;
  endfunction

  logic fixedAny;
  assign fixedAny = opt.sourceAddressMode | opt.destinationAddressMode;
  assign opt.srcSpan = opt.sourceAddressMode ?
                       spanOf(opt.fifoWidthCode) : '0;
  assign opt.dstSpan = opt.destinationAddressMode ?
                       spanOf(opt.fifoWidthCode) : '0;
  // a reserved code only matters while some side is fixed
  assign opt.codeBad = fixedAny &&
                       (opt.fifoWidthCode > FWC_LAST_LEGAL);
endmodule

// File: design/dpd_addr_step.sv
`timescale 1ns/1ps
module dpd_addr_step #(
  parameter int ADDR_W = 32
) (
  dpd_opt_if.step opt
);
  import dpd_pkg::*;

  if (ADDR_W != 32)
    $error("dpd_addr_step serves 32-bit byte addresses only");

  // stepping side moves past the whole array; fixed side returns to start
  assign opt.nextSrc = opt.sourceAddressMode ?
    opt.sourceStartAddress :
    opt.sourceStartAddress + {16'h0000, opt.bytesPerArray};
  assign opt.nextDst = opt.destinationAddressMode ?
    opt.destinationStartAddress :
    opt.destinationStartAddress + {16'h0000, opt.bytesPerArray};
endmodule

// File: design/dpd_channel_entry.sv
`timescale 1ns/1ps
// How it works
// - width code matters only with fixed addressing
// - width codes 0-5 give 8-256 bits; 6-7 reserved
// - hold clear: entry updated or linked after submit
// - hold set: entry untouched, no link
// - dimension 0: one array per trigger
// - dimension 1: whole frame per trigger
// - destination stepping mode walks upward, plain memory
// - destination fixed mode wraps at fifo span
// - source stepping mode walks upward, plain memory
// - source fixed mode wraps at fifo span
// - source word is the 32-bit read start
// - upper counts half is arrays per frame
// - lower counts half is bytes per array
// - destination word is the 32-bit write start
// - all-ones link pointer means no reload
module dpd_channel_entry (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        ce,
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  input  wire logic        triggerEvent,
  output logic             jobValid,
  input  wire logic        jobReady,
  output logic [31:0]      jobSrc,
  output logic [31:0]      jobDst,
  output logic [15:0]      jobBytes,
  output logic [15:0]      jobArrays,
  output logic [5:0]       jobSrcSpan,
  output logic [5:0]       jobDstSpan
);
  import dpd_pkg::*;

  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  be);
    for (int i = 0; i < 4; i++)
      mergeBytes[8*i +: 8] = be[i] ? data[8*i +: 8] : old[8*i +: 8];
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // trigger pin synchroniser
  logic syncA, syncB, syncC, evLevel;
  logic next_evLevel, evRise;

  always_comb
  begin
    next_evLevel = (syncB == syncC) ? syncC : evLevel;
  end
  assign evRise = ce && next_evLevel && !evLevel;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      syncA   <= 1'b0;
      syncB   <= 1'b0;
      syncC   <= 1'b0;
      evLevel <= 1'b0;
    end
    else if (ce)
    begin
      syncA   <= triggerEvent;
      syncB   <= syncA;
      syncC   <= syncB;
      evLevel <= next_evLevel;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then the answer for one cycle
  logic [31:0] next_readdata;
  logic        next_waitrequest, wrEn;
  logic [31:0] ctrl, src, cnt, dst, lCtrl, lSrc, lCnt, lDst;
  logic [15:0] link;
  logic        refused, missed, pending, exhausted;
  dpd_state_type state;
  logic [31:0] statusWord;

  assign wrEn = ce && write && !waitrequest;
  assign statusWord = {27'h0, pending, missed, refused, exhausted,
                       state != ST_IDLE};

  always_comb
  begin
    next_waitrequest = 1'b1;
    next_readdata    = readdata;
    if ((read || write) && waitrequest)
    begin
      next_waitrequest = 1'b0;
      unique case (address)
        OFF_CTRL:  next_readdata = ctrl;
        OFF_SRC:   next_readdata = src;
        OFF_CNT:   next_readdata = cnt;
        OFF_DST:   next_readdata = dst;
        OFF_LINK:  next_readdata = {16'h0000, link};
        OFF_STAT:  next_readdata = statusWord;
        OFF_LCTRL: next_readdata = lCtrl;
        OFF_LSRC:  next_readdata = lSrc;
        OFF_LCNT:  next_readdata = lCnt;
        OFF_LDST:  next_readdata = lDst;
        default:   next_readdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end
    else if (ce)
    begin
      waitrequest <= next_waitrequest;
      readdata    <= next_readdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // option decode and address stepping
  dpd_opt_if opt ();
  assign opt.fifoWidthCode = ctrl[FWC_LSB +: FWC_W];
  assign opt.sourceAddressMode = ctrl[BIT_SRC_MODE];
  assign opt.destinationAddressMode = ctrl[BIT_DST_MODE];
  assign opt.sourceStartAddress = src;
  assign opt.destinationStartAddress = dst;
  assign opt.bytesPerArray = cnt[BYTES_LSB +: CNT_W];

  dpd_span_decode u_span (
    .opt (opt)
  );
  dpd_addr_step #(
    .ADDR_W (32)
  ) u_step (
    .opt (opt)
  );

  //////////////////////////////////////////////////////////////////////////
  // entry, event and job sequencing
  logic [31:0] next_ctrl, next_src, next_cnt, next_dst;
  logic [31:0] next_lCtrl, next_lSrc, next_lCnt, next_lDst;
  logic [15:0] next_link, arrays, bytes;
  logic        next_refused, next_missed, next_pending, next_exhausted;
  logic        next_jobValid, softEv, newEv, take, entryOk, lastArray;
  dpd_state_type next_state;
  logic [31:0] next_jobSrc, next_jobDst;
  logic [15:0] next_jobBytes, next_jobArrays;
  logic [5:0]  next_jobSrcSpan, next_jobDstSpan;

  assign arrays  = cnt[ARRAYS_LSB +: CNT_W];
  assign bytes   = cnt[BYTES_LSB +: CNT_W];
  assign softEv  = wrEn && address == OFF_TRIG && byteenable[0] &&
                   writedata[TRIG_BIT];
  assign newEv   = evRise || softEv;
  // zero counts, and reserved codes while a side is fixed, are refused rather than guessed at
  assign entryOk = bytes != '0 && arrays != '0 && !opt.codeBad;
  assign take    = ce && state == ST_IDLE && pending;
  assign lastArray = ctrl[BIT_DIM] || arrays == 16'h0001;

  always_comb
  begin
    next_ctrl = ctrl;  next_src = src;  next_cnt = cnt;  next_dst = dst;
    next_lCtrl = lCtrl; next_lSrc = lSrc; next_lCnt = lCnt;
    next_lDst = lDst;  next_link = link;
    next_state = state;
    next_jobValid = jobValid;
    next_jobSrc = jobSrc;  next_jobDst = jobDst;
    next_jobBytes = jobBytes;  next_jobArrays = jobArrays;
    next_jobSrcSpan = jobSrcSpan;  next_jobDstSpan = jobDstSpan;
    next_exhausted = exhausted;
    next_refused = refused;
    next_missed  = missed;
    // a fresh event is kept even while the old one is taken
    next_pending = (pending && !take) || newEv;
    if (newEv && pending && !take)
      next_missed = 1'b1;
    if (wrEn)
    begin
      unique case (address)
        OFF_CTRL:  next_ctrl  = mergeBytes(ctrl, writedata, byteenable);
        OFF_SRC:   next_src   = mergeBytes(src, writedata, byteenable);
        OFF_CNT:   next_cnt   = mergeBytes(cnt, writedata, byteenable);
        OFF_DST:   next_dst   = mergeBytes(dst, writedata, byteenable);
        OFF_LINK:  next_link  = 16'(mergeBytes({16'h0000, link},
                                               writedata, byteenable));
        OFF_LCTRL: next_lCtrl = mergeBytes(lCtrl, writedata, byteenable);
        OFF_LSRC:  next_lSrc  = mergeBytes(lSrc, writedata, byteenable);
        OFF_LCNT:  next_lCnt  = mergeBytes(lCnt, writedata, byteenable);
        OFF_LDST:  next_lDst  = mergeBytes(lDst, writedata, byteenable);
        OFF_STAT:
        begin
          // write one to clear; a same-cycle hardware set still wins
          if (byteenable[0] && writedata[ST_REFUSED])
            next_refused = 1'b0;
          if (byteenable[0] && writedata[ST_MISSED] && !(newEv && pending))
            next_missed = 1'b0;
        end
        default: ;
      endcase
      if (address == OFF_CNT && mergeBytes(cnt, writedata, byteenable)
          != 32'h0000_0000)
        next_exhausted = 1'b0;
    end
    unique case (state)
      ST_IDLE:
      begin
        if (take && entryOk)
        begin
          next_state      = ST_ISSUE;
          next_jobValid   = 1'b1;
          next_jobSrc     = src;
          next_jobDst     = dst;
          next_jobBytes   = bytes;
          next_jobArrays  = ctrl[BIT_DIM] ? arrays : 16'h0001;
          next_jobSrcSpan = opt.srcSpan;
          next_jobDstSpan = opt.dstSpan;
        end
        else if (take)
          next_refused = 1'b1;
      end
      ST_ISSUE:
      begin
        if (jobReady)
        begin
          next_jobValid = 1'b0;
          next_state    = ST_UPDATE;
        end
      end
      ST_UPDATE:
      begin
        next_state = ST_IDLE;
        if (!ctrl[BIT_HOLD])
        begin
          next_src = opt.nextSrc;
          next_dst = opt.nextDst;
          next_cnt[ARRAYS_LSB +: CNT_W] = lastArray ? 16'h0000 :
                                          arrays - 16'h0001;
          if (lastArray && link != NULL_LINK)
          begin
            next_ctrl = lCtrl;
            next_src  = lSrc;
            next_cnt  = lCnt;
            next_dst  = lDst;
            next_link = NULL_LINK;
          end
          else if (lastArray)
            next_exhausted = 1'b1;
        end
      end
      default:
      begin
        next_state    = ST_IDLE;
        next_jobValid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl <= RST_WORD;  src <= RST_WORD;  cnt <= RST_WORD;
      dst <= RST_WORD;   lCtrl <= RST_WORD; lSrc <= RST_WORD;
      lCnt <= RST_WORD;  lDst <= RST_WORD;  link <= RST_LINK;
      state <= ST_IDLE;  jobValid <= 1'b0;
      jobSrc <= RST_WORD; jobDst <= RST_WORD;
      jobBytes <= '0;    jobArrays <= '0;
      jobSrcSpan <= '0;  jobDstSpan <= '0;
      refused <= 1'b0;   missed <= 1'b0;
      pending <= 1'b0;   exhausted <= 1'b0;
    end
    else if (ce)
    begin
      ctrl <= next_ctrl;  src <= next_src;  cnt <= next_cnt;
      dst <= next_dst;    lCtrl <= next_lCtrl; lSrc <= next_lSrc;
      lCnt <= next_lCnt;  lDst <= next_lDst;   link <= next_link;
      state <= next_state; jobValid <= next_jobValid;
      jobSrc <= next_jobSrc; jobDst <= next_jobDst;
      jobBytes <= next_jobBytes; jobArrays <= next_jobArrays;
      jobSrcSpan <= next_jobSrcSpan; jobDstSpan <= next_jobDstSpan;
      refused <= next_refused; missed <= next_missed;
      pending <= next_pending; exhausted <= next_exhausted;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence sLaunch;
    ce && state == ST_IDLE && pending && entryOk;
  endsequence
  sequence sStep;
    ce && state == ST_UPDATE && !ctrl[BIT_HOLD] && !wrEn && !lastArray;
  endsequence
  a_job_src_start: assert property (sLaunch |=>
    jobValid && jobSrc == $past(src)) else $error("job source wrong");
  a_job_dst_start: assert property (sLaunch |=>
    jobDst == $past(dst)) else $error("job destination wrong");
  a_one_array: assert property ((sLaunch and !ctrl[BIT_DIM]) |=>
    jobArrays == 16'h0001) else $error("array count not one");
  a_whole_frame: assert property ((sLaunch and ctrl[BIT_DIM]) |=>
    jobArrays == $past(arrays) && jobBytes == $past(bytes))
    else $error("frame count wrong");
  a_hold_keeps: assert property (
    ce && state == ST_UPDATE && ctrl[BIT_HOLD] && !wrEn |=>
    $stable(cnt) && $stable(src) && $stable(dst) && $stable(link))
    else $error("held entry changed");
  a_src_steps: assert property ((sStep and !ctrl[BIT_SRC_MODE]) |=>
    src == $past(src) + {16'h0000, $past(bytes)} &&
    arrays == $past(arrays) - 16'h0001) else $error("source not stepped");
  a_src_fixed: assert property ((sStep and ctrl[BIT_SRC_MODE]) |=>
    $stable(src)) else $error("fixed source moved");
  a_dst_fixed: assert property ((sStep and ctrl[BIT_DST_MODE]) |=>
    $stable(dst)) else $error("fixed destination moved");
  a_null_link: assert property (
    ce && state == ST_UPDATE && !ctrl[BIT_HOLD] && lastArray &&
    link == NULL_LINK && !wrEn |=> arrays == 16'h0000 && exhausted)
    else $error("null link reloaded");
  a_span_fixed: assert property (
    !ctrl[BIT_SRC_MODE] && !ctrl[BIT_DST_MODE] |->
    opt.srcSpan == '0 && opt.dstSpan == '0 && !opt.codeBad)
    else $error("span without fixed mode");
  a_bad_refused: assert property (
    ce && take && opt.codeBad |=> !jobValid && refused)
    else $error("reserved code launched");
  a_code_reserved: assert property (
    ctrl[BIT_SRC_MODE] && ctrl[FWC_LSB +: FWC_W] > FWC_LAST_LEGAL |->
    opt.codeBad && opt.srcSpan == '0) else $error("reserved code decoded");
endmodule

// File: verif/dma_channel_setup_entry_set_transfer_decode_tb.sv
`timescale 1ns/1ps
module dma_channel_setup_entry_set_transfer_decode_tb;
  import dpd_pkg::*;
  logic        clock;
  logic        arst_n;
  logic        ce;
  logic [5:0]  address;
  logic        read;
  logic        write;
  logic [3:0]  byteenable;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        triggerEvent;
  logic        jobValid;
  logic        jobReady;
  logic [31:0] jobSrc;
  logic [31:0] jobDst;
  logic [15:0] jobBytes;
  logic [15:0] jobArrays;
  logic [5:0]  jobSrcSpan;
  logic [5:0]  jobDstSpan;
  int          err_count;
  int          num_checks;

  dpd_channel_entry u_dut (
    .clock(clock), .arst_n(arst_n), .ce(ce), .address(address),
    .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .triggerEvent(triggerEvent),
    .jobValid(jobValid), .jobReady(jobReady), .jobSrc(jobSrc),
    .jobDst(jobDst), .jobBytes(jobBytes), .jobArrays(jobArrays),
    .jobSrcSpan(jobSrcSpan), .jobDstSpan(jobDstSpan)
  );

  always #2.5 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until waitrequest is sampled low at a rising edge
  task automatic busXfer(input logic wr, input logic [5:0] addr,
                         input logic [31:0] data, output logic [31:0] rd);
    int n;
    @(posedge clock);
    read <= ~wr;
    write <= wr;
    address <= addr;
    writedata <= data;
    byteenable <= 4'hF;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50)
      chk(32'h0000_0000, 32'h0000_0001);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic regWrite(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] x;
    busXfer(1'b1, a, d, x);
  endtask

  task automatic regCheck(input logic [5:0] a, input logic [31:0] e,
                          input logic [31:0] mask = 32'hFFFF_FFFF);
    logic [31:0] x;
    busXfer(1'b0, a, 32'h0000_0000, x);
    chk(x & mask, e);
  endtask

  // waits for a job, compares its fields, then accepts it
  task automatic takeJob(input logic [31:0] s, input logic [31:0] d,
                         input logic [15:0] b, input logic [15:0] n,
                         input logic [5:0] ss, input logic [5:0] ds);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 80 && !seen; i++)
    begin
      @(posedge clock);
      seen = (jobValid === 1'b1);
    end
    chk({31'h0, seen}, 32'h0000_0001);
    chk(jobSrc, s);
    chk(jobDst, d);
    chk({jobBytes, jobArrays}, {b, n});
    chk({26'h0, jobSrcSpan}, {26'h0, ss});
    chk({26'h0, jobDstSpan}, {26'h0, ds});
    jobReady <= 1'b1;
    @(posedge clock);
    jobReady <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  task automatic pinPulse();
    @(posedge clock);
    triggerEvent <= 1'b1;
    repeat (8) @(posedge clock);
    triggerEvent <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic testReset();
    regCheck(OFF_CTRL, RST_WORD);
    regCheck(OFF_LINK, {16'h0000, RST_LINK});
    regCheck(6'h3C, 32'h0000_0000);
    $display("test reset done");
  endtask

  // stepping both sides, one array per trigger, entry updated
  task automatic testStep();
    regWrite(OFF_SRC, 32'h1000_0000);
    regWrite(OFF_DST, 32'h2000_0040);
    regWrite(OFF_CNT, 32'h0002_0010);
    regWrite(OFF_CTRL, 32'h0000_0300);
    regCheck(OFF_SRC, 32'h1000_0000);
    regCheck(OFF_DST, 32'h2000_0040);
    regCheck(OFF_CNT, 32'h0002_0010);
    regWrite(OFF_TRIG, 32'h0000_0001);
    takeJob(32'h1000_0000, 32'h2000_0040, 16'h0010, 16'h0001, 6'h00,
            6'h00);
    regCheck(OFF_SRC, 32'h1000_0010);
    regCheck(OFF_DST, 32'h2000_0050);
    regCheck(OFF_CNT, 32'h0001_0010);
    regWrite(OFF_TRIG, 32'h0000_0001);
    takeJob(32'h1000_0010, 32'h2000_0050, 16'h0010, 16'h0001, 6'h00,
            6'h00);
    regCheck(OFF_STAT, 32'h0000_0002, 32'h0000_0002);
    $display("test step done");
  endtask

  // every legal width code, whole frame per trigger, entry held
  task automatic testFrame();
    logic [31:0] ctrl;
    logic [5:0]  span;
    regWrite(OFF_SRC, 32'h5000_0100);
    regWrite(OFF_DST, 32'h6000_0200);
    regWrite(OFF_CNT, 32'h0003_0020);
    for (int c = 0; c <= 5; c++)
    begin
      span = 6'h01 << c;
      ctrl = (32'(c) << 8) | 32'h0000_000D | ((c % 2 == 0) ? 32'h2 : 32'h0);
      regWrite(OFF_CTRL, ctrl);
      pinPulse();
      takeJob(32'h5000_0100, 32'h6000_0200, 16'h0020, 16'h0003, span,
              (c % 2 == 0) ? span : 6'h00);
      regCheck(OFF_SRC, 32'h5000_0100);
      regCheck(OFF_DST, 32'h6000_0200);
      regCheck(OFF_CNT, 32'h0003_0020);
    end
    $display("test frame done");
  endtask

  // reserved width codes with a fixed side are refused
  task automatic testReserved();
    logic seen;
    for (int c = 6; c <= 7; c++)
    begin
      regWrite(OFF_CTRL, (32'(c) << 8) | 32'h0000_0001);
      regWrite(OFF_TRIG, 32'h0000_0001);
      seen = 1'b0;
      repeat (20)
      begin
        @(posedge clock);
        seen = seen | (jobValid === 1'b1);
      end
      chk({31'h0, seen}, 32'h0000_0000);
      regCheck(OFF_STAT, 32'h0000_0004, 32'h0000_0004);
      regWrite(OFF_STAT, 32'h0000_0004);
      regCheck(OFF_STAT, 32'h0000_0000, 32'h0000_0004);
    end
    $display("test reserved done");
  endtask

  // exhausted entry is replaced from the link target
  task automatic testLink();
    regWrite(OFF_LCTRL, 32'h0000_0000);
    regWrite(OFF_LSRC, 32'h3000_0000);
    regWrite(OFF_LCNT, 32'h0001_0008);
    regWrite(OFF_LDST, 32'h4000_0000);
    regWrite(OFF_SRC, 32'h7000_0000);
    regWrite(OFF_DST, 32'h7100_0000);
    regWrite(OFF_CNT, 32'h0002_0004);
    regWrite(OFF_CTRL, 32'h0000_0004);
    regWrite(OFF_LINK, 32'h0000_0000);
    regWrite(OFF_TRIG, 32'h0000_0001);
    takeJob(32'h7000_0000, 32'h7100_0000, 16'h0004, 16'h0002, 6'h00,
            6'h00);
    regCheck(OFF_SRC, 32'h3000_0000);
    regCheck(OFF_DST, 32'h4000_0000);
    regCheck(OFF_CNT, 32'h0001_0008);
    regCheck(OFF_LINK, 32'h0000_FFFF);
    regWrite(OFF_TRIG, 32'h0000_0001);
    takeJob(32'h3000_0000, 32'h4000_0000, 16'h0008, 16'h0001, 6'h00,
            6'h00);
    regCheck(OFF_STAT, 32'h0000_0002, 32'h0000_0002);
    $display("test link done");
  endtask

  // events arriving while one is pending set missed
  task automatic testMissed();
    regWrite(OFF_SRC, 32'h0800_0000);
    regWrite(OFF_DST, 32'h0900_0000);
    regWrite(OFF_CNT, 32'h0001_0004);
    regWrite(OFF_CTRL, 32'h0000_0008);
    repeat (3) regWrite(OFF_TRIG, 32'h0000_0001);
    regCheck(OFF_STAT, 32'h0000_0019, 32'h0000_0019);
    takeJob(32'h0800_0000, 32'h0900_0000, 16'h0004, 16'h0001, 6'h00,
            6'h00);
    takeJob(32'h0800_0000, 32'h0900_0000, 16'h0004, 16'h0001, 6'h00,
            6'h00);
    regWrite(OFF_STAT, 32'h0000_0008);
    regCheck(OFF_STAT, 32'h0000_0000, 32'h0000_0018);
    $display("test missed done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    arst_n = 1'b0;
    ce = 1'b1;
    address = 6'h00;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'h0;
    writedata = 32'h0000_0000;
    triggerEvent = 1'b0;
    jobReady = 1'b0;
    err_count = 0;
    num_checks = 0;
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    testReset();
    testStep();
    testFrame();
    testReserved();
    testLink();
    testMissed();
    end_of_test();
  end

  // whole run needs under a thousand cycles; 40000 cycles is far beyond it
  initial
  begin
    #200000;
    err_count++;
    end_of_test();
  end
endmodule
